// ==== common/rtc_tod_defines.svh ====
// constants of the time-of-day column block: register indices, field masks,
// wrap values and timing; included by the package and the design files.
// Behaviour
// - seconds: BCD bits 6-0, 00-59, bit7 zero
// - seconds register exists only on clock page
// - minutes: BCD bits 6-0, 00-59, bit7 zero
// - minutes present on clock and alarm pages
// - hours on both pages, bits 7-6 zero
// - format select 1: 24-hour BCD 00-23
// - format select 0: bit5 PM, BCD 0-11
// - page bit steers shared column addresses
`ifndef RTC_TOD_DEFINES_SVH
`define RTC_TOD_DEFINES_SVH

// register indices; byte address is four times the index
`define RTC_IDX_SEC 4'h0
`define RTC_IDX_MIN 4'h1
`define RTC_IDX_HOUR 4'h2
`define RTC_IDX_FMT 4'h6
`define RTC_IDX_PAGE 4'h8

// field widths and masks
`define RTC_SEC_W 7
`define RTC_MIN_W 7
`define RTC_HOUR_W 6
`define RTC_MINSEC_MAX 7'h59
`define RTC_HOUR24_MAX 6'h23
`define RTC_HOUR12_MAX 5'h11
`define RTC_HOUR12_WRAP 6'h31
`define RTC_PM_BIT 5

// control bit positions in the page and format registers
`define RTC_PAGE_SEL_BIT 0
`define RTC_RUN_BIT 3
`define RTC_FMT_BIT 0

// reset values
`define RTC_TIME_RST 8'h00
`define RTC_FMT_RST 1'b0
`define RTC_CTRL_RST 1'b0

// timing: one-second tick from a 4 ns clock
`define RTC_TICK_NS 1000000000
`define RTC_CLK_NS 4
`define RTC_DIV_W 28

`endif

// ==== common/rtc_tod_pkg.sv ====
// types and helpers shared by the time-of-day block and its field counter.
// assumes the defines header sits beside it on the include path.
`include "rtc_tod_defines.svh"
package rtc_tod_pkg;

	// one bus request as seen by the register decoder
	typedef struct packed {
		logic [3:0] idx;
		logic aligned;
		logic we;
		logic lane0;
		logic [7:0] dat;
	} wb_req_t;

	// the running time, one BCD field each
	typedef struct packed {
		logic [`RTC_HOUR_W-1:0] hour;
		logic [`RTC_MIN_W-1:0] min;
		logic [`RTC_SEC_W-1:0] sec;
	} tod_t;

	// bcd increment of two digits; caller handles the wrap value
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v + 8'h01;
		if (v[3:0] == 4'h9) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end
		return r;
	endfunction

endpackage

// ==== design/bcd_field_counter.sv ====
// one BCD minute or second field: loads from software, steps on inc_i.
// assumes load and inc come from the same clock; load wins over a step.
`timescale 1ns/10ps
`include "rtc_tod_defines.svh"
module bcd_field_counter #(
	parameter int W = 7,
	parameter logic [6:0] MAXV = `RTC_MINSEC_MAX
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	input wire logic inc_i,
	output logic [W-1:0] val_o,
	output logic wrap_o
);

	logic [W-1:0] val_r; // current field value
	logic [7:0] stepped; // value after one bcd step
	logic [W-1:0] val_nxt;

	assign stepped = rtc_tod_pkg::bcd_inc({{(8-W){1'b0}}, val_r});
	assign wrap_o = inc_i && (val_r == MAXV[W-1:0]);
	// a software load in the tick cycle wins, so a set time is never lost
	assign val_nxt = load_i ? load_val_i :
		wrap_o ? '0 :
		inc_i ? stepped[W-1:0] : val_r;

	// field register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			val_r <= '0;
		end else begin
			val_r <= val_nxt;
		end
	end

	assign val_o = val_r;

endmodule

// ==== design/rtc_tod_fields.sv ====
// time-of-day column registers: seconds, minutes and hours on the clock
// page, minutes and hours on the alarm page, behind a classic wishbone slave.
// assumes a 250 MHz clock; the one-second tick is divided down from it.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`include "rtc_tod_defines.svh"
module rtc_tod_fields #(
	parameter int TICK_CYCLES = `RTC_TICK_NS / `RTC_CLK_NS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic day_carry_o
);

	////////////////////////////////////////////////////////////////////////
	// bus decode

	rtc_tod_pkg::wb_req_t req; // request fields gathered
	logic take; // request accepted this edge
	logic wr; // write accepted this edge
	logic hit_sec, hit_min, hit_hour, hit_fmt, hit_page;

	assign req = '{idx: adr_i[5:2], aligned: (adr_i[1:0] == 2'h0), we: we_i,
		lane0: sel_i[0], dat: dat_i[7:0]};
	assign take = cyc_i && stb_i && !ack_o;
	assign wr = take && req.we && req.lane0;
	// address decode; unaligned addresses hit nothing
	assign hit_sec = req.aligned && (req.idx == `RTC_IDX_SEC);
	assign hit_min = req.aligned && (req.idx == `RTC_IDX_MIN);
	assign hit_hour = req.aligned && (req.idx == `RTC_IDX_HOUR);
	assign hit_fmt = req.aligned && (req.idx == `RTC_IDX_FMT);
	assign hit_page = req.aligned && (req.idx == `RTC_IDX_PAGE);

	////////////////////////////////////////////////////////////////////////
	// control state

	logic page_r; // 0 clock page, 1 alarm page
	logic run_r; // clock running
	logic fmt24_r; // 1 selects 24-hour form
	logic [`RTC_MIN_W-1:0] alm_min_r; // alarm page minutes
	logic [`RTC_HOUR_W-1:0] alm_hour_r; // alarm page hours
	logic [`RTC_HOUR_W-1:0] hour_r; // clock page hours
	logic [`RTC_DIV_W-1:0] div_r; // tick divider
	logic tick; // one-cycle one-second enable

	// control writes; format register is only reachable on the alarm page
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			page_r <= `RTC_CTRL_RST;
			run_r <= `RTC_CTRL_RST;
			fmt24_r <= `RTC_FMT_RST;
		end else begin
			if (wr && hit_page) begin
				page_r <= req.dat[`RTC_PAGE_SEL_BIT];
				run_r <= req.dat[`RTC_RUN_BIT];
			end
			if (wr && hit_fmt && page_r) begin
				fmt24_r <= req.dat[`RTC_FMT_BIT];
			end
		end
	end

	// divider restarts while stopped so the first second after start is whole
	assign tick = run_r && (div_r == `RTC_DIV_W'(TICK_CYCLES - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_r || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + `RTC_DIV_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock page counters

	logic [`RTC_SEC_W-1:0] sec_q;
	logic [`RTC_MIN_W-1:0] min_q;
	logic sec_wrap, min_wrap, hour_wrap;
	logic wr_clk; // write aimed at the clock page
	logic [7:0] hour_step; // bcd step of the hour digits
	logic [`RTC_HOUR_W-1:0] hour_inc;

	assign wr_clk = wr && !page_r;

	// seconds exist only on the clock page
	bcd_field_counter #(.W(`RTC_SEC_W), .MAXV(`RTC_MINSEC_MAX)) u_sec (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(wr_clk && hit_sec),
		.load_val_i(req.dat[`RTC_SEC_W-1:0]),
		.inc_i(tick),
		.val_o(sec_q),
		.wrap_o(sec_wrap)
	);

	bcd_field_counter #(.W(`RTC_MIN_W), .MAXV(`RTC_MINSEC_MAX)) u_min (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(wr_clk && hit_min),
		.load_val_i(req.dat[`RTC_MIN_W-1:0]),
		.inc_i(sec_wrap),
		.val_o(min_q),
		.wrap_o(min_wrap)
	);

	// hour step: 24-hour wraps 23 to 00, 12-hour wraps 11 to 0 and flips pm
	// both tens bits take part, so 24-hour 19 steps to 20 rather than 00
	assign hour_step = rtc_tod_pkg::bcd_inc({2'h0, hour_r});
	assign hour_wrap = min_wrap && (fmt24_r ? (hour_r == `RTC_HOUR24_MAX) :
		(hour_r == `RTC_HOUR12_WRAP));
	assign hour_inc = fmt24_r ?
		((hour_r == `RTC_HOUR24_MAX) ? 6'h00 : hour_step[5:0]) :
		((hour_r[4:0] == `RTC_HOUR12_MAX) ? {~hour_r[`RTC_PM_BIT], 5'h00} :
		{hour_r[`RTC_PM_BIT], hour_step[4:0]});

	// clock hours; a software write wins over a carry in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hour_r <= `RTC_HOUR_W'(`RTC_TIME_RST);
		end else if (wr_clk && hit_hour) begin
			hour_r <= req.dat[`RTC_HOUR_W-1:0];
		end else if (min_wrap) begin
			hour_r <= hour_inc;
		end
	end

	// alarm page minutes and hours; plain storage, same layout as clock page
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alm_min_r <= `RTC_MIN_W'(`RTC_TIME_RST);
			alm_hour_r <= `RTC_HOUR_W'(`RTC_TIME_RST);
		end else if (wr && page_r) begin
			if (hit_min) begin
				alm_min_r <= req.dat[`RTC_MIN_W-1:0];
			end
			if (hit_hour) begin
				alm_hour_r <= req.dat[`RTC_HOUR_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux and answer

	logic [7:0] rd_byte; // selected register, unused bits zero
	// reads capture the live counters; a carry between two reads can tear them
	assign rd_byte = hit_sec ? (page_r ? 8'h00 : {1'b0, sec_q}) :
		hit_min ? {1'b0, (page_r ? alm_min_r : min_q)} :
		hit_hour ? {2'h0, (page_r ? alm_hour_r : hour_r)} :
		hit_fmt ? {7'h00, (page_r & fmt24_r)} :
		hit_page ? {4'h0, run_r, 2'h0, page_r} : 8'h00;

	// one-cycle ack after each request; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
			day_carry_o <= 1'b0;
		end else begin
			ack_o <= take;
			if (take && !req.we) begin
				dat_o <= {24'h000000, rd_byte};
			end
			day_carry_o <= hour_wrap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	sequence s_sec_read_alarm;
		take && !we_i && hit_sec && page_r;
	endsequence
	sequence s_hour24_roll;
		fmt24_r && min_wrap && !wr && (hour_r == 6'h23);
	endsequence
	sequence s_hour12_roll;
		!fmt24_r && min_wrap && !wr && (hour_r == 6'h11);
	endsequence

	a_sec_bit7_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && !we_i && hit_sec) |=> (dat_o[7] == 1'b0))
		else $error("seconds read shows bit 7 set");
	a_sec_alarm_none: assert property (@(posedge clk_i) disable iff (rst_i)
		s_sec_read_alarm |=> (dat_o == 32'h00000000))
		else $error("seconds read on alarm page not zero");
	a_sec_wrap_carry: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr && sec_q == 7'h59) |=> (sec_q == 7'h00 && $changed(min_q)))
		else $error("seconds wrap did not carry into minutes");
	a_min_page_split: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && page_r && hit_min && !sec_wrap) |=> $stable(min_q) && alm_min_r == $past(dat_i[6:0]))
		else $error("alarm minute write touched clock minutes");
	a_hour_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && !we_i && hit_hour) |=> (dat_o[7:6] == 2'h0 && ack_o))
		else $error("hour read shows top bits or no ack");
	a_hour24_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
		s_hour24_roll |=> (hour_r == 6'h00 && day_carry_o))
		else $error("24-hour form did not wrap 23 to 00");
	a_hour12_pm: assert property (@(posedge clk_i) disable iff (rst_i)
		s_hour12_roll |=> (hour_r == 6'h20 && !day_carry_o))
		else $error("12-hour form did not turn 11 am into 0 pm");
	a_page_steer: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && hit_page) |=> (page_r == $past(dat_i[0])) ##1 ack_o == 1'b0)
		else $error("page select not taken from write data");

endmodule

// ==== dv/tb_rtc_tod_fields.sv ====
// self-checking bench for the time-of-day column registers.
// assumes a classic wishbone slave that answers one cycle after taking a request.
`timescale 1ns/10ps
module tb_rtc_tod_fields;
	localparam int TC = 8; // short tick so a second passes in a few cycles
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_o;
	logic ack_o, day_carry_o;
	int err_count = 0, n_tests = 0, cyc_n = 0, carries = 0;
	////////////////////////////////////////////////////////////////////////
	rtc_tod_fields #(.TICK_CYCLES(TC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_o),
		.ack_o(ack_o), .day_carry_o(day_carry_o));
	// clock and watchdog; the ceiling is far above the few hundred cycles needed
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_n++;
		if (day_carry_o === 1'b1) carries++;
		if (cyc_n == 20000) begin
			err_count++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		if (err_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle; the request holds until ack is sampled high
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [7:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_w <= {24'h0, d};
		// no local limit: only the bench watchdog ends a hung wait
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, 4'h1, q);
	endtask
	// software reads twice and compares both captures
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] q1, q2;
		wb(1'b0, a, 8'h00, 4'h1, q1);
		wb(1'b0, a, 8'h00, 4'h1, q2);
		chk(q1, exp);
		chk(q2, q1);
	endtask
	// run for exactly one tick, then stop before the second
	task automatic one_tick();
		wr(6'h20, 8'h08);
		repeat (TC + 1) @(posedge clk_i);
		wr(6'h20, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_fields();
		rd(6'h00, 8'h00);
		wr(6'h00, 8'hd9);
		rd(6'h00, 8'h59);
		wr(6'h04, 8'hd9);
		rd(6'h04, 8'h59);
		wr(6'h08, 8'he3);
		rd(6'h08, 8'h23);
		rd(6'h0c, 8'h00);
		rd(6'h01, 8'h00);
	endtask
	task automatic t_pages();
		logic [7:0] q;
		wb(1'b1, 6'h00, 8'h12, 4'h0, q);
		rd(6'h00, 8'h59);
		wr(6'h20, 8'h01);
		rd(6'h00, 8'h00);
		wr(6'h00, 8'h33);
		wr(6'h04, 8'h30);
		wr(6'h08, 8'h11);
		rd(6'h04, 8'h30);
		rd(6'h08, 8'h11);
		wr(6'h20, 8'h00);
		rd(6'h00, 8'h59);
		rd(6'h04, 8'h59);
		rd(6'h08, 8'h23);
	endtask
	task automatic t_roll24();
		wr(6'h20, 8'h01);
		wr(6'h18, 8'h01);
		rd(6'h18, 8'h01);
		wr(6'h20, 8'h00);
		carries = 0;
		one_tick();
		rd(6'h00, 8'h00);
		rd(6'h04, 8'h00);
		rd(6'h08, 8'h00);
		chk(8'(carries), 8'h01);
		// the tens digit of the hour must step too: 19 turns into 20
		wr(6'h00, 8'h59);
		wr(6'h04, 8'h59);
		wr(6'h08, 8'h19);
		one_tick();
		rd(6'h08, 8'h20);
	endtask
	task automatic t_roll12();
		wr(6'h20, 8'h01);
		wr(6'h18, 8'h00);
		wr(6'h20, 8'h00);
		wr(6'h00, 8'h09);
		one_tick();
		rd(6'h00, 8'h10);
		rd(6'h04, 8'h00);
		wr(6'h00, 8'h59);
		wr(6'h04, 8'h59);
		wr(6'h08, 8'h11);
		carries = 0;
		one_tick();
		rd(6'h08, 8'h20);
		chk(8'(carries), 8'h00);
		wr(6'h00, 8'h59);
		wr(6'h04, 8'h59);
		wr(6'h08, 8'h31);
		one_tick();
		rd(6'h08, 8'h00);
		chk(8'(carries), 8'h01);
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence: reset for ten cycles, then every scenario in turn
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_fields();
		t_pages();
		t_roll24();
		t_roll12();
		conclude();
	end
endmodule
